// ==== verification/boot_host_model.sv ====
// Host computer model on the boot serial link
`timescale 1ns/10ps
module boot_host_model (
    // Clock
    input  wire logic pclk,
    // Serial lines
    input  wire logic txd,
    output logic      rxd
);
    int bt = 90;
    // Idle high through reset release
    initial rxd = 1'b1;
    // LSB first, one stop bit, no parity
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bt) @(posedge pclk);
        end
    endtask
    task automatic recv(output logic [7:0] b, output logic ok);
        int n = 0;
        b = 8'h00;
        while (txd && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bt) @(posedge pclk);
            b[i] = txd;
        end
        repeat (bt) @(posedge pclk);
        ok = txd && (n < 5000);
    endtask
endmodule // boot_host_model

// ==== verification/onboard_boot_loader_checker.sv ====
// Port assertions for the boot loader
`timescale 1ns/10ps
module onboard_boot_loader_checker
    import boot_loader_pkg::*;
(
    // Clock, reset, straps, watchdog and flash status
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        chip_reset_pin_n,
    input wire logic        flash_write_enable_pin,
    input wire logic        mode_select_pin_2,
    input wire logic        mode_select_pin_1,
    input wire logic        mode_select_pin_0,
    input wire logic        wdt_overflow,
    input wire logic        flash_blank,
    // Watched outputs
    input wire logic        flash_erase_all_req,
    input wire logic        ram_wr_en,
    input wire logic [23:0] ram_wr_addr,
    input wire logic        loader_area_reserved,
    input wire logic        branch_pulse,
    input wire logic [23:0] branch_addr,
    input wire logic        boot_serial_transmit_pin_out,
    input wire logic        boot_serial_transmit_pin_oe,
    input wire logic        boot_mode,
    input wire logic        user_program_mode,
    input wire logic        expanded_bus_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] pins;
    assign pins = {flash_write_enable_pin, mode_select_pin_2, mode_select_pin_1, mode_select_pin_0};
    // Six cycles covers the pin sync lag
    sequence held;
        (!chip_reset_pin_n && $stable(pins))[*6];
    endsequence
    AST_BOOT_DECODE: assert property (held |-> boot_mode == (pins[3] & ~pins[2] & pins[1]))
        else $error("boot decode wrong");
    AST_USER_DECODE: assert property (held |-> user_program_mode == (pins[3] & pins[2] & pins[1]))
        else $error("user decode wrong");
    AST_BUS_PINS: assert property (held |-> expanded_bus_mode == (pins[1] & ~pins[0]))
        else $error("bus pin mode wrong");
    AST_BRANCH_ADDR: assert property (branch_pulse |-> branch_addr == PROG_AREA_START)
        else $error("branch address wrong");
    AST_RAM_AREA: assert property (ram_wr_en |-> ram_wr_addr inside {[PROG_AREA_START:PROG_AREA_END]})
        else $error("ram write outside area");
    AST_TX_PARKED: assert property (branch_pulse |=> (boot_serial_transmit_pin_oe && boot_serial_transmit_pin_out)[*4])
        else $error("transmit pin not parked high");
    AST_AREA_FREE: assert property (branch_pulse |-> ##[0:2] !loader_area_reserved)
        else $error("loader area still reserved");
    AST_ERASE_REQ: assert property ($rose(flash_erase_all_req) |-> !flash_blank)
        else $error("erase of blank flash");
    AST_WDT_END: assert property (wdt_overflow |-> ##[1:3] !boot_serial_transmit_pin_oe)
        else $error("watchdog did not end boot");
    cover property (branch_pulse);
    cover property (ram_wr_en);
    cover property (held ##0 boot_mode);
endmodule // onboard_boot_loader_checker

bind onboard_boot_loader onboard_boot_loader_checker u_checker (.*);

// ==== verification/onboard_boot_loader_tb.sv ====
// Self-checking bench for the boot loader
`timescale 1ns/10ps
module onboard_boot_loader_tb;
    import boot_loader_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_reset_pin_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, dv;
    logic [3:0]  straps;
    logic        flash_write_enable_pin, mode_select_pin_2, mode_select_pin_1, mode_select_pin_0;
    logic        boot_serial_receive_pin, boot_serial_transmit_pin_out, boot_serial_transmit_pin_oe;
    logic        wdt_overflow, flash_blank, flash_erase_done, flash_erase_all_req;
    logic        flash_read_block, ram_wr_en, loader_area_reserved, branch_pulse, e, ok;
    logic        boot_mode, user_program_mode, expanded_bus_mode, txd;
    logic        address_strobe_en, high_byte_write_strobe_en;
    logic [4:0]  mo;
    logic [23:0] ram_wr_addr, branch_addr;
    logic [7:0]  ram_wr_data, b;
    logic [23:0] wa[$];
    logic [7:0]  wd[$];
    logic [7:0]  img[$];
    int          num_errors = 0;
    int          samples_checked = 0;
    int          br = 0;
    assign {flash_write_enable_pin, mode_select_pin_2, mode_select_pin_1, mode_select_pin_0} = straps;
    // Board pull-up holds the line while undriven
    assign txd = boot_serial_transmit_pin_oe ? boot_serial_transmit_pin_out : 1'b1;
    assign mo  = {boot_mode, user_program_mode, expanded_bus_mode, address_strobe_en,
                  high_byte_write_strobe_en};

    onboard_boot_loader u_dut (.*);
    boot_host_model u_host (.pclk(pclk), .txd(txd), .rxd(boot_serial_receive_pin));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (ram_wr_en === 1'b1) begin
            wa.push_back(ram_wr_addr);
            wd.push_back(ram_wr_data);
        end
        if (branch_pulse === 1'b1) br++;
    end

    function automatic logic [4:0] exp_mode(input logic [3:0] s);
        return {s[3] & ~s[2] & s[1], s[3] & s[2] & s[1], {3{s[1] & ~s[0]}}};
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            complete_run;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        int len;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {chip_reset_pin_n, wdt_overflow, flash_blank, flash_erase_done} = '0;
        straps = 4'hA;
        void'($urandom(32'hD882));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int m = 0; m < 16; m++) begin
            straps <= m[3:0];
            repeat (8) @(posedge pclk);
            chk("mode", exp_mode(m[3:0]), mo);
        end
        $display("test straps done");
        straps <= {3'b101, 1'($urandom)};
        ok = 1'b0;
        for (int t = 0; t < 2 && !ok; t++) begin
            chip_reset_pin_n <= 1'b0;
            repeat (24) @(posedge pclk);
            // Pins stay fixed for the whole boot
            chip_reset_pin_n <= 1'b1;
            repeat (110) @(posedge pclk);
            fork
                repeat (2) u_host.send(8'h00);
                u_host.recv(b, ok);
            join
        end
        chk("ack", {1'b1, ACK_BYTE}, {ok, b});
        apb(1'b0, REG_BAUD_DIV, 32'h0);
        dv = r;
        chk("divisor", 1, (r >= 89 && r <= 90));
        u_host.send(SYNC_BYTE);
        chk("erase", 1, flash_erase_all_req);
        flash_erase_done <= 1'b1;
        @(posedge pclk);
        flash_erase_done <= 1'b0;
        len = 2 + $urandom % 3;
        u_host.send(8'(len >> 8));
        u_host.send(8'(len));
        for (int i = 0; i < len; i++) begin
            img.push_back(8'($urandom));
            u_host.send(img[i]);
        end
        for (int n = 0; n < 300 && br == 0; n++) @(posedge pclk);
        chk("writes", len, wa.size());
        foreach (img[i]) begin
            chk("addr", PROG_AREA_START + i, wa[i]);
            chk("data", img[i], wd[i]);
        end
        chk("branch", {1'b1, PROG_AREA_START}, {br == 1, branch_addr});
        chk("park", 3'b110, {boot_serial_transmit_pin_oe, txd, loader_area_reserved});
        apb(1'b0, REG_SERIAL_CTRL, 32'h0);
        chk("serial", 0, r[1:0]);
        apb(1'b0, REG_BAUD_DIV, 32'h0);
        chk("divkeep", dv, r);
        $display("test boot load done");
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 1, e);
        apb(1'b1, REG_FLASH_CTRL, 32'h1);
        chk("readblock", 1, flash_read_block);
        apb(1'b1, REG_FLASH_CTRL, 32'h0);
        wdt_overflow <= 1'b1;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("watchdog", 1, loader_area_reserved);
        $display("test registers and watchdog done");
        complete_run;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        complete_run;
    end
endmodule // onboard_boot_loader_tb

// ==== verilog/boot_loader_pkg.sv ====
// Constants shared by the boot loader and its serial helpers
package boot_loader_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ              = 25_000_000;

    // Startup delay after reset release, in clock states
    localparam logic [6:0]  STARTUP_WAIT_STATES = 7'h64;

    // A zero byte is low for start bit plus eight data bits
    localparam logic [3:0]  LOW_BIT_TIMES       = 4'h9;
    localparam int unsigned DATA_BITS           = 8;

    // Handshake bytes
    localparam logic [7:0]  ACK_BYTE            = 8'h00;
    localparam logic [7:0]  SYNC_BYTE           = 8'h55;

    // Loader RAM areas
    localparam logic [23:0] LOADER_AREA_START   = 24'hFFDC00;
    localparam logic [23:0] LOADER_AREA_END     = 24'hFFE3FF;
    localparam logic [23:0] PROG_AREA_START     = 24'hFFE400;
    localparam logic [23:0] PROG_AREA_END       = 24'hFFFB7F;
    localparam logic [23:0] WORK_AREA_START     = 24'hFFFB80;
    localparam logic [23:0] WORK_AREA_END       = 24'hFFFBFF;
    localparam logic [15:0] PROG_MAX_LEN        = 16'(PROG_AREA_END - PROG_AREA_START + 24'h1);

    // Register byte offsets
    localparam logic [11:0] REG_FLASH_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS          = 12'h004;
    localparam logic [11:0] REG_BAUD_DIV        = 12'h008;
    localparam logic [11:0] REG_SERIAL_CTRL     = 12'h00C;
    localparam logic [11:0] REG_PROG_LEN        = 12'h010;

    // Field positions
    localparam int unsigned SWE_BIT             = 0;
    localparam int unsigned RX_ON_BIT           = 0;
    localparam int unsigned TX_ON_BIT           = 1;

    // Reset values
    localparam logic [15:0] BAUD_DIV_RESET      = 16'h0001;
    localparam logic [5:0]  PIN_FILT_RESET      = 6'h30;

endpackage

// ==== verilog/onboard_boot_loader.sv ====
// Boot mode loader with mode strap decode and APB status registers
`timescale 1ns/10ps
module onboard_boot_loader (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        chip_reset_pin_n,
    input  wire logic        flash_write_enable_pin,
    input  wire logic        mode_select_pin_2,
    input  wire logic        mode_select_pin_1,
    input  wire logic        mode_select_pin_0,
    input  wire logic        boot_serial_receive_pin,
    output logic             boot_serial_transmit_pin_out,
    output logic             boot_serial_transmit_pin_oe,
    // Watchdog
    input  wire logic        wdt_overflow,
    // Flash
    input  wire logic        flash_blank,
    input  wire logic        flash_erase_done,
    output logic             flash_erase_all_req,
    output logic             flash_read_block,
    // RAM loading
    output logic             ram_wr_en,
    output logic      [23:0] ram_wr_addr,
    output logic      [7:0]  ram_wr_data,
    output logic             loader_area_reserved,
    // Branch to loaded program
    output logic             branch_pulse,
    output logic      [23:0] branch_addr,
    // Mode outputs
    output logic             boot_mode,
    output logic             user_program_mode,
    output logic             expanded_bus_mode,
    output logic             address_strobe_en,
    output logic             high_byte_write_strobe_en
);
    import boot_loader_pkg::*;

    typedef enum logic [3:0] {
        S_WAIT    = 4'b0000,
        S_IDLE_HI = 4'b0001,
        S_MEASURE = 4'b0011,
        S_ACK     = 4'b0010,
        S_SYNC    = 4'b0110,
        S_ERASE   = 4'b0111,
        S_LEN_HI  = 4'b0101,
        S_LEN_LO  = 4'b0100,
        S_LOAD    = 4'b1100,
        S_SHUT    = 4'b1101,
        S_RUN     = 4'b1111,
        S_OFF     = 4'b1110
    } ldr_state_e;

    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [5:0]  filt;
        ldr_state_e  st;
        logic [6:0]  wait_cnt;
        logic [3:0]  pre9;
        logic [15:0] divisor;
        logic [15:0] len;
        logic [15:0] cnt;
        logic [3:0]  straps;
        logic        rx_on;
        logic        tx_on;
        logic        tx_start;
        logic        software_write_enable_bit;
        logic        erase_req;
        logic        ram_we;
        logic [23:0] ram_addr;
        logic [7:0]  ram_data;
        logic        branch;
        logic        tx_dir;
        logic        tx_out;
        logic [31:0] prdata;
    } ldr_s;

    ldr_s q;
    ldr_s d;

    logic       rst_pin_f;
    logic       rxd_f;
    logic [3:0] pins_f;
    logic       is_boot;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       tx_line;
    logic       tx_done;
    logic       wr_acc;
    logic       rd_setup;
    logic       mapped;

    // Filtered pins: {reset, rxd, fwe, md2, md1, md0}; reset bit is active high, rxd idles high, both load high at reset
    assign rst_pin_f = q.filt[5];
    assign rxd_f     = q.filt[4];
    assign pins_f    = q.filt[3:0];
    assign is_boot   = q.straps[3] & ~q.straps[2] & q.straps[1];

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == REG_FLASH_CTRL) || (paddr == REG_STATUS)
                   || (paddr == REG_BAUD_DIV) || (paddr == REG_SERIAL_CTRL)
                   || (paddr == REG_PROG_LEN);

    serial_rx u_rx (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (q.rx_on),
        .divisor  (q.divisor),
        .rxd      (rxd_f),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid)
    );

    serial_tx u_tx (
        .pclk     (pclk),
        .presetn  (presetn),
        .divisor  (q.divisor),
        .start    (q.tx_start),
        .tx_byte  (ACK_BYTE),
        .txd      (tx_line),
        .done     (tx_done)
    );

    always_comb begin
        d          = q;
        d.tx_start = 1'b0;
        d.ram_we   = 1'b0;
        d.branch   = 1'b0;

        // Three-stage sync; a change counts once stages two and three agree
        d.s1   = {~chip_reset_pin_n, boot_serial_receive_pin, flash_write_enable_pin,
                  mode_select_pin_2, mode_select_pin_1, mode_select_pin_0};
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.filt = (q.s2 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));

        // Write enable drops with the pin
        if (!pins_f[3]) begin
            d.software_write_enable_bit = 1'b0;
        end

        if (rst_pin_f || wdt_overflow) begin
            // Straps follow the pins while reset is held
            d.straps    = pins_f;
            d.st        = S_WAIT;
            d.wait_cnt  = 7'h00;
            d.rx_on     = 1'b0;
            d.tx_on     = 1'b0;
            d.software_write_enable_bit       = 1'b0;
            d.erase_req = 1'b0;
            d.tx_dir    = 1'b0;
            d.tx_out    = 1'b0;
        end else begin
            unique case (q.st)
                S_WAIT: begin
                    if (!is_boot) begin
                        d.st = S_OFF;
                    end else if (q.wait_cnt == STARTUP_WAIT_STATES - 7'h01) begin
                        d.st = S_IDLE_HI;
                    end else begin
                        d.wait_cnt = q.wait_cnt + 7'h01;
                    end
                end
                S_IDLE_HI: begin
                    // Falling edge of the first zero byte starts timing
                    if (!rxd_f) begin
                        d.st      = S_MEASURE;
                        d.pre9    = 4'h1;
                        d.divisor = 16'h0000;
                    end
                end
                S_MEASURE: begin
                    if (!rxd_f) begin
                        // One divisor step per nine low cycles
                        if (q.pre9 == LOW_BIT_TIMES - 4'h1) begin
                            d.pre9 = 4'h0;
                            if (q.divisor != 16'hFFFF) begin
                                d.divisor = q.divisor + 16'h0001;
                            end
                        end else begin
                            d.pre9 = q.pre9 + 4'h1;
                        end
                    end else begin
                        if (q.divisor == 16'h0000) begin
                            d.divisor = BAUD_DIV_RESET;
                        end
                        d.rx_on    = 1'b1;
                        d.tx_on    = 1'b1;
                        d.tx_start = 1'b1;
                        d.st       = S_ACK;
                    end
                end
                S_ACK: begin
                    if (tx_done) begin
                        d.st = S_SYNC;
                    end
                end
                S_SYNC: begin
                    // Stray zero bytes are ignored until the sync byte
                    if (rx_valid && rx_byte == SYNC_BYTE) begin
                        if (flash_blank) begin
                            d.st = S_LEN_HI;
                        end else begin
                            d.st        = S_ERASE;
                            d.erase_req = 1'b1;
                        end
                    end
                end
                S_ERASE: begin
                    if (flash_erase_done) begin
                        d.erase_req = 1'b0;
                        d.st        = S_LEN_HI;
                    end
                end
                S_LEN_HI: begin
                    if (rx_valid) begin
                        d.len[15:8] = rx_byte;
                        d.st        = S_LEN_LO;
                    end
                end
                S_LEN_LO: begin
                    if (rx_valid) begin
                        d.cnt = 16'h0000;
                        if ({q.len[15:8], rx_byte} == 16'h0000) begin
                            d.len = 16'h0000;
                            d.st  = S_SHUT;
                        end else if ({q.len[15:8], rx_byte} > PROG_MAX_LEN) begin
                            // Oversize image is cut at the end of the program area
                            d.len = PROG_MAX_LEN;
                            d.st  = S_LOAD;
                        end else begin
                            d.len = {q.len[15:8], rx_byte};
                            d.st  = S_LOAD;
                        end
                    end
                end
                S_LOAD: begin
                    if (rx_valid) begin
                        d.ram_we   = 1'b1;
                        d.ram_data = rx_byte;
                        d.ram_addr = PROG_AREA_START + {8'h00, q.cnt};
                        d.cnt      = q.cnt + 16'h0001;
                        if (q.cnt + 16'h0001 == q.len) begin
                            d.st = S_SHUT;
                        end
                    end
                end
                S_SHUT: begin
                    // Divisor is left as measured
                    d.rx_on  = 1'b0;
                    d.tx_on  = 1'b0;
                    d.tx_dir = 1'b1;
                    d.tx_out = 1'b1;
                    d.branch = 1'b1;
                    d.st     = S_RUN;
                end
                S_RUN, S_OFF: begin
                    if (wr_acc && paddr == REG_SERIAL_CTRL) begin
                        d.rx_on = pwdata[RX_ON_BIT];
                        d.tx_on = pwdata[TX_ON_BIT];
                    end
                    if (wr_acc && paddr == REG_BAUD_DIV) begin
                        d.divisor = pwdata[15:0];
                    end
                end
                default: begin
                    d.st = S_WAIT;
                end
            endcase

            // Write enable only takes with the pin high
            if (wr_acc && paddr == REG_FLASH_CTRL) begin
                d.software_write_enable_bit = pwdata[SWE_BIT] & pins_f[3];
            end
        end

        // Read data captured in the setup phase
        if (rd_setup) begin
            unique case (paddr)
                REG_FLASH_CTRL:  d.prdata = {31'h0, q.software_write_enable_bit};
                REG_STATUS:      d.prdata = {12'h000, q.erase_req, loader_area_reserved,
                                             user_program_mode, is_boot, 4'h0, q.st,
                                             q.straps, 4'h0};
                REG_BAUD_DIV:    d.prdata = {16'h0000, q.divisor};
                REG_SERIAL_CTRL: d.prdata = {30'h0, q.tx_on, q.rx_on};
                REG_PROG_LEN:    d.prdata = {q.cnt, q.len};
                default:         d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.filt    <= PIN_FILT_RESET;
            q.s1      <= PIN_FILT_RESET;
            q.s2      <= PIN_FILT_RESET;
            q.s3      <= PIN_FILT_RESET;
            q.st      <= S_WAIT;
            q.divisor <= BAUD_DIV_RESET;
        end else begin
            q <= d;
        end
    end

    // APB answers without wait states
    assign prdata  = q.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Serial unit owns the pin while enabled, otherwise the port bits do
    assign boot_serial_transmit_pin_out = q.tx_on ? tx_line : q.tx_out;
    assign boot_serial_transmit_pin_oe  = q.tx_on | q.tx_dir;

    assign flash_erase_all_req  = q.erase_req;
    assign flash_read_block     = q.software_write_enable_bit;
    assign ram_wr_en            = q.ram_we;
    assign ram_wr_addr          = q.ram_addr;
    assign ram_wr_data          = q.ram_data;
    // Loader and working areas stay claimed until the branch
    assign loader_area_reserved = is_boot && q.st != S_RUN;
    assign branch_pulse         = q.branch;
    assign branch_addr          = PROG_AREA_START;

    assign boot_mode                 = is_boot;
    assign user_program_mode         = q.straps[3] & q.straps[2] & q.straps[1];
    assign expanded_bus_mode         = q.straps[1] & ~q.straps[0];
    assign address_strobe_en         = expanded_bus_mode;
    assign high_byte_write_strobe_en = expanded_bus_mode;
endmodule // onboard_boot_loader

// ==== verilog/serial_rx.sv ====
// Asynchronous serial receiver, 8 data bits, 1 stop bit, no parity
`timescale 1ns/10ps
module serial_rx (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        enable,
    input  wire logic [15:0] divisor,
    input  wire logic        rxd,
    // Received byte
    output logic      [7:0]  rx_byte,
    output logic             rx_valid
);
    import boot_loader_pkg::*;

    typedef enum logic [1:0] {R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b11,
                              R_STOP = 2'b10} rx_state_e;
    typedef struct packed {
        rx_state_e   st;
        logic [15:0] cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  shift;
        logic        valid;
    } rx_s;

    rx_s q;
    rx_s d;

    always_comb begin
        d       = q;
        d.valid = 1'b0;
        if (!enable) begin
            d.st = R_IDLE;
        end else begin
            unique case (q.st)
                R_IDLE: begin
                    if (!rxd) begin
                        d.st  = R_START;
                        d.cnt = {1'b0, divisor[15:1]};
                    end
                end
                R_START: begin
                    if (q.cnt == 16'h0000) begin
                        // Glitch shorter than half a bit is dropped
                        d.st      = rxd ? R_IDLE : R_DATA;
                        d.cnt     = divisor - 16'h0001;
                        d.bit_idx = 3'h0;
                    end else begin
                        d.cnt = q.cnt - 16'h0001;
                    end
                end
                R_DATA: begin
                    if (q.cnt == 16'h0000) begin
                        d.shift   = {rxd, q.shift[7:1]};
                        d.cnt     = divisor - 16'h0001;
                        d.bit_idx = q.bit_idx + 3'h1;
                        if (q.bit_idx == 3'(DATA_BITS - 1)) begin
                            d.st = R_STOP;
                        end
                    end else begin
                        d.cnt = q.cnt - 16'h0001;
                    end
                end
                R_STOP: begin
                    if (q.cnt == 16'h0000) begin
                        d.st    = R_IDLE;
                        d.valid = rxd;
                    end else begin
                        d.cnt = q.cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rx_byte  = q.shift;
    assign rx_valid = q.valid;
endmodule // serial_rx

// ==== verilog/serial_tx.sv ====
// Asynchronous serial transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/10ps
module serial_tx (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic [15:0] divisor,
    input  wire logic        start,
    input  wire logic [7:0]  tx_byte,
    // Line and status
    output logic             txd,
    output logic             done
);
    import boot_loader_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [9:0]  shift;
        logic [3:0]  left;
        logic [15:0] cnt;
        logic        done;
    } tx_s;

    tx_s q;
    tx_s d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (!q.busy) begin
            if (start) begin
                d.busy  = 1'b1;
                d.shift = {1'b1, tx_byte, 1'b0};
                d.left  = 4'(DATA_BITS + 2);
                d.cnt   = divisor;
            end
        end else if (q.cnt == 16'h0001 || q.cnt == 16'h0000) begin
            d.shift = {1'b1, q.shift[9:1]};
            d.cnt   = divisor;
            d.left  = q.left - 4'h1;
            if (q.left == 4'h1) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end else begin
            d.cnt = q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{busy: 1'b0, shift: 10'h3FF, left: 4'h0, cnt: 16'h0000, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Idle line stays high
    assign txd  = q.busy ? q.shift[0] : 1'b1;
    assign done = q.done;
endmodule // serial_tx
